// ---- inc/hpcr_defines.svh ----
// Register indices, field positions, masks and reset values of the hub port configuration block
`ifndef HPCR_DEFINES_SVH
`define HPCR_DEFINES_SVH

// Register indices; byte address is four times the index
`define HPCR_IDX_BYTE2 6'h07
`define HPCR_IDX_BYTE3 6'h08
`define HPCR_IDX_FIXED 6'h09
`define HPCR_IDX_SPOFF 6'h0A
`define HPCR_IDX_BPOFF 6'h0B

// Reset values
`define HPCR_RST_BYTE2 8'h28
`define HPCR_RST_BYTE3 8'h03
`define HPCR_RST_FIXED 8'h06
`define HPCR_RST_SPOFF 8'h00
`define HPCR_RST_BPOFF 8'h00

// Writable bits; all others are reserved and read back their reset value
`define HPCR_WMASK_BYTE2 8'h08
`define HPCR_WMASK_BYTE3 8'h09
`define HPCR_WMASK_PORTS 8'h0E

// Field positions
`define HPCR_BIT_COMPOUND 3
`define HPCR_BIT_NUMSEL 3
`define HPCR_BIT_STRING 0
`define HPCR_PORT_LO 1
`define HPCR_PORT_HI 3

`endif

// ---- inc/hpcr_pkg.sv ----
// Types shared by the hub port configuration block
package hpcr_pkg;
  typedef logic [7:0] hpcr_byte_t;
  typedef logic [1:0] hpcr_portnum_t;
  typedef logic [3:1] hpcr_portvec_t;
endpackage

// ---- hdl/hpcr_sync.sv ----
// Two-stage synchroniser for one level from outside the clock domain
`timescale 1ns/1ns
module hpcr_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Level
  input wire logic async_in,
  output logic sync_out
);
  logic stage_one;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_one <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule // hpcr_sync

// ---- hdl/hpcr_port_map.sv ----
// Port disable selection, contiguous renumbering and descriptor bitmap, combinational
`timescale 1ns/1ns
`include "hpcr_defines.svh"
module hpcr_port_map import hpcr_pkg::*; (
  // Mode
  input wire logic port_numbering_select,
  input wire logic self_pow,
  // Masks
  input wire hpcr_portvec_t self_power_off_bits,
  input wire hpcr_portvec_t bus_power_off_bits,
  input wire hpcr_portvec_t fixed_attach_bits,
  input wire hpcr_portnum_t [3:1] remap_port_number,
  // Results
  output hpcr_portvec_t port_enabled,
  output hpcr_portnum_t [3:1] port_number,
  output hpcr_portnum_t enabled_port_count,
  output hpcr_portvec_t desc_fixed_attach
);
  hpcr_portvec_t off_bits;
  hpcr_portvec_t std_en;

  // Masks only count in standard numbering; supply mode picks which one
  assign off_bits = port_numbering_select ? '0 :
                    (self_pow ? self_power_off_bits : bus_power_off_bits);
  assign std_en = ~off_bits;

  genvar p, q;
  generate
    for (p = `HPCR_PORT_LO; p <= `HPCR_PORT_HI; p++) begin : g_port
      hpcr_portvec_t lower;
      hpcr_portnum_t std_num;
      hpcr_portvec_t hit;
      assign lower = hpcr_portvec_t'((1 << (p - 1)) - 1);
      // Ports below this one that stay on set its reported number
      assign std_num = std_en[p] ? hpcr_portnum_t'($countones(std_en & lower) + 1) : '0;
      assign port_number[p] = port_numbering_select ? remap_port_number[p] : std_num;
      assign port_enabled[p] = port_number[p] != '0;
      // Descriptor bit p is for reported port p, so reordering carries the flag along
      for (q = `HPCR_PORT_LO; q <= `HPCR_PORT_HI; q++) begin : g_hit
        assign hit[q] = fixed_attach_bits[q] && (port_number[q] == hpcr_portnum_t'(p));
      end
      assign desc_fixed_attach[p] = |hit;
    end
  endgenerate

  assign enabled_port_count = hpcr_portnum_t'($countones(port_enabled));
endmodule // hpcr_port_map

// ---- hdl/hpcr_top.sv ----
// Hub port configuration registers: APB slave, register bytes and registered port report
// Notes on behaviour
// - Bit 3 of config byte two flags the hub as part of a compound device.
// - Bit 3 of config byte three selects port numbering and disable method.
// - Select at 0: ports keep numbers, higher ones close gaps left by disabled ones.
// - Select at 1: numbers come from re-map inputs; disable masks ignored.
// - Bit 0 of config byte three enables string descriptor support.
// - Fixed-attach mask bits 1..3 map to ports 1..3; others reserved.
// - Descriptor report shows which active ports carry fixed devices.
// - Self-powered with select 0: ports with off bit set are disabled.
// - Any disable combination allowed; enabled count reported, active ports reordered.
// - Self-power off mask bits 1..3 control ports 1..3; others reserved.
// - Bus-powered with select 0: bus-power off mask applies instead.
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
`include "hpcr_defines.svh"
module hpcr_top import hpcr_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Supply mode pin, high when self-powered
  input wire logic self_powered_pin,
  // Re-map table numbers from outside, 0 means port off
  input wire hpcr_portnum_t [3:1] remap_port_number,
  // Settings
  output logic compound_flag,
  output logic port_numbering_select,
  output logic string_enable,
  output hpcr_portvec_t fixed_attach_bits,
  // Port report to the enumeration logic
  output hpcr_portvec_t port_enabled,
  output hpcr_portnum_t [3:1] port_number,
  output hpcr_portnum_t enabled_port_count,
  output hpcr_portvec_t desc_fixed_attach
);
  localparam logic [7:0] ADDR_BYTE2 = {`HPCR_IDX_BYTE2, 2'b00};
  localparam logic [7:0] ADDR_BYTE3 = {`HPCR_IDX_BYTE3, 2'b00};
  localparam logic [7:0] ADDR_FIXED = {`HPCR_IDX_FIXED, 2'b00};
  localparam logic [7:0] ADDR_SPOFF = {`HPCR_IDX_SPOFF, 2'b00};
  localparam logic [7:0] ADDR_BPOFF = {`HPCR_IDX_BPOFF, 2'b00};

  hpcr_byte_t config_byte_two;
  hpcr_byte_t config_byte_three;
  hpcr_byte_t fixed_attach_port_mask;
  hpcr_byte_t self_power_port_off_mask;
  hpcr_byte_t bus_power_port_off_mask;
  logic self_pow;
  logic setup_phase;
  logic wr_en;
  logic addr_hit;
  hpcr_byte_t next_rd_byte;
  hpcr_portvec_t map_enabled;
  hpcr_portnum_t [3:1] map_number;
  hpcr_portnum_t map_count;
  hpcr_portvec_t map_desc;

  // Supply mode pin is asynchronous to pclk
  hpcr_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(self_powered_pin),
    .sync_out(self_pow)
  );

  // Zero wait states; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign setup_phase = psel && !penable;
  assign addr_hit = (paddr == ADDR_BYTE2) || (paddr == ADDR_BYTE3) || (paddr == ADDR_FIXED) ||
                    (paddr == ADDR_SPOFF) || (paddr == ADDR_BPOFF);
  assign pslverr = psel && penable && !addr_hit;
  // Only byte lane 0 holds data; other lanes are ignored
  assign wr_en = psel && penable && pwrite && addr_hit && pstrb[0];

  // Reserved bits never stored, so they read back their reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_byte_two <= `HPCR_RST_BYTE2;
    end else if (wr_en && paddr == ADDR_BYTE2) begin
      config_byte_two <= (pwdata[7:0] & `HPCR_WMASK_BYTE2) | (`HPCR_RST_BYTE2 & ~`HPCR_WMASK_BYTE2);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_byte_three <= `HPCR_RST_BYTE3;
    end else if (wr_en && paddr == ADDR_BYTE3) begin
      config_byte_three <= (pwdata[7:0] & `HPCR_WMASK_BYTE3) | (`HPCR_RST_BYTE3 & ~`HPCR_WMASK_BYTE3);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fixed_attach_port_mask <= `HPCR_RST_FIXED;
    end else if (wr_en && paddr == ADDR_FIXED) begin
      fixed_attach_port_mask <= pwdata[7:0] & `HPCR_WMASK_PORTS;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      self_power_port_off_mask <= `HPCR_RST_SPOFF;
    end else if (wr_en && paddr == ADDR_SPOFF) begin
      self_power_port_off_mask <= pwdata[7:0] & `HPCR_WMASK_PORTS;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_power_port_off_mask <= `HPCR_RST_BPOFF;
    end else if (wr_en && paddr == ADDR_BPOFF) begin
      bus_power_port_off_mask <= pwdata[7:0] & `HPCR_WMASK_PORTS;
    end
  end

  // Read mux
  always_comb begin
    next_rd_byte = '0;
    case (paddr)
      ADDR_BYTE2: next_rd_byte = config_byte_two;
      ADDR_BYTE3: next_rd_byte = config_byte_three;
      ADDR_FIXED: next_rd_byte = fixed_attach_port_mask;
      ADDR_SPOFF: next_rd_byte = self_power_port_off_mask;
      ADDR_BPOFF: next_rd_byte = bus_power_port_off_mask;
      default: next_rd_byte = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_phase && !pwrite) begin
      prdata <= {24'h000000, next_rd_byte};
    end
  end

  hpcr_port_map u_map (
    .port_numbering_select(config_byte_three[`HPCR_BIT_NUMSEL]),
    .self_pow(self_pow),
    .self_power_off_bits(self_power_port_off_mask[`HPCR_PORT_HI:`HPCR_PORT_LO]),
    .bus_power_off_bits(bus_power_port_off_mask[`HPCR_PORT_HI:`HPCR_PORT_LO]),
    .fixed_attach_bits(fixed_attach_port_mask[`HPCR_PORT_HI:`HPCR_PORT_LO]),
    .remap_port_number(remap_port_number),
    .port_enabled(map_enabled),
    .port_number(map_number),
    .enabled_port_count(map_count),
    .desc_fixed_attach(map_desc)
  );

  // Settings outputs follow the register bytes one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compound_flag <= 1'b1;
      port_numbering_select <= 1'b0;
      string_enable <= 1'b1;
      fixed_attach_bits <= '0;
    end else begin
      compound_flag <= config_byte_two[`HPCR_BIT_COMPOUND];
      port_numbering_select <= config_byte_three[`HPCR_BIT_NUMSEL];
      string_enable <= config_byte_three[`HPCR_BIT_STRING];
      fixed_attach_bits <= fixed_attach_port_mask[`HPCR_PORT_HI:`HPCR_PORT_LO];
    end
  end

  // Port report registered so enumeration sees a glitch-free snapshot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_enabled <= '0;
      port_number <= '0;
      enabled_port_count <= '0;
      desc_fixed_attach <= '0;
    end else begin
      port_enabled <= map_enabled;
      port_number <= map_number;
      enabled_port_count <= map_count;
      desc_fixed_attach <= map_desc;
    end
  end

  // Checks
  sequence s_write(logic [7:0] addr);
    psel && penable && pwrite && pstrb[0] && paddr == addr;
  endsequence

  sequence s_read(logic [7:0] addr);
    psel && !penable && !pwrite && paddr == addr ##1 psel && penable;
  endsequence

  a_compound_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_write(ADDR_BYTE2) |=> ##1 compound_flag == $past(pwdata[3], 2))
    else $error("compound flag does not follow write");

  a_numsel_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_write(ADDR_BYTE3) |=> ##1 port_numbering_select == $past(pwdata[3], 2))
    else $error("numbering select does not follow write");

  a_string_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_write(ADDR_BYTE3) |=> ##1 string_enable == $past(pwdata[0], 2))
    else $error("string enable does not follow write");

  a_reserved_read: assert property (@(posedge pclk) disable iff (!presetn)
    s_read(ADDR_BYTE2) |->
    prdata[7:0] == ((config_byte_two & `HPCR_WMASK_BYTE2) | (`HPCR_RST_BYTE2 & ~`HPCR_WMASK_BYTE2)))
    else $error("reserved bits of config byte two altered");

  a_fixed_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    s_write(ADDR_FIXED) |=> fixed_attach_port_mask[0] == 1'b0 && fixed_attach_port_mask[7:4] == 4'h0)
    else $error("reserved fixed-attach bits stored");

  a_first_port_one: assert property (@(posedge pclk) disable iff (!presetn)
    !config_byte_three[3] && self_pow && !self_power_port_off_mask[1] |=> port_number[1] == 2'h1)
    else $error("port 1 not reported as number 1");

  a_gap_closed: assert property (@(posedge pclk) disable iff (!presetn)
    !config_byte_three[3] && self_pow && self_power_port_off_mask[2:1] == 2'h1 && !self_power_port_off_mask[3]
    |=> port_number[2] == 2'h1 && port_number[3] == 2'h2)
    else $error("higher ports not renumbered contiguously");

  a_remap_used: assert property (@(posedge pclk) disable iff (!presetn)
    config_byte_three[3] |=> port_number == $past(remap_port_number))
    else $error("re-map numbers not applied");

  a_self_disable: assert property (@(posedge pclk) disable iff (!presetn)
    !config_byte_three[3] && self_pow && self_power_port_off_mask[3] |=> !port_enabled[3])
    else $error("self-powered disabled port still enabled");

  a_bus_disable: assert property (@(posedge pclk) disable iff (!presetn)
    !config_byte_three[3] && !self_pow && bus_power_port_off_mask[2] |=> !port_enabled[2])
    else $error("bus-powered disabled port still enabled");

  a_port_count: assert property (@(posedge pclk) disable iff (!presetn)
    enabled_port_count == 2'($countones(port_enabled)))
    else $error("enabled port count mismatch");

  a_fixed_report: assert property (@(posedge pclk) disable iff (!presetn)
    !config_byte_three[3] && self_pow && self_power_port_off_mask[3:1] == 3'h0 && fixed_attach_port_mask[2]
    |=> desc_fixed_attach[2])
    else $error("fixed-attach port not reported");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && paddr == 8'h00 |-> pslverr)
    else $error("unmapped address not flagged");

  a_byte3_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    s_read(ADDR_BYTE3) |->
    (prdata[7:0] & ~`HPCR_WMASK_BYTE3) == (`HPCR_RST_BYTE3 & ~`HPCR_WMASK_BYTE3))
    else $error("reserved bits of config byte three altered");

  a_read_upper: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("read data outside byte lane 0");

  // A refused write must leave every byte as it was
  sequence s_blocked_write;
    psel && penable && pwrite && (!pstrb[0] || !addr_hit);
  endsequence

  a_blocked_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_blocked_write |=> $stable(config_byte_two) && $stable(config_byte_three) && $stable(fixed_attach_port_mask) &&
    $stable(self_power_port_off_mask) && $stable(bus_power_port_off_mask))
    else $error("refused write changed a register");

  a_fixed_follow: assert property (@(posedge pclk) disable iff (!presetn)
    s_write(ADDR_FIXED) |=> ##1 fixed_attach_bits == $past(pwdata[3:1], 2))
    else $error("fixed-attach bits do not follow write");

  a_self_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    s_write(ADDR_SPOFF) |=> self_power_port_off_mask[0] == 1'b0 && self_power_port_off_mask[7:4] == 4'h0)
    else $error("reserved self-power off bits stored");

  a_bus_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    s_write(ADDR_BPOFF) |=> bus_power_port_off_mask[0] == 1'b0 && bus_power_port_off_mask[7:4] == 4'h0)
    else $error("reserved bus-power off bits stored");

  a_bus_renumber: assert property (@(posedge pclk) disable iff (!presetn)
    !config_byte_three[`HPCR_BIT_NUMSEL] && !self_pow && bus_power_port_off_mask[3:1] == 3'h1
    |=> port_number[2] == 2'h1 && port_number[3] == 2'h2 && enabled_port_count == 2'h2)
    else $error("bus-powered ports not renumbered");

  a_count_all_on: assert property (@(posedge pclk) disable iff (!presetn)
    !config_byte_three[`HPCR_BIT_NUMSEL] && self_pow && self_power_port_off_mask[3:1] == 3'h0
    |=> enabled_port_count == 2'h3)
    else $error("all-on count not three");

  // Re-map numbers are taken as given; duplicates are not flagged
  a_remap_mask: assert property (@(posedge pclk) disable iff (!presetn)
    config_byte_three[`HPCR_BIT_NUMSEL] |=> port_enabled ==
    {$past(remap_port_number[3]) != 2'h0, $past(remap_port_number[2]) != 2'h0, $past(remap_port_number[1]) != 2'h0})
    else $error("re-map mode still applies a disable mask");

  a_desc_inactive: assert property (@(posedge pclk) disable iff (!presetn)
    !port_numbering_select && desc_fixed_attach[3] |-> enabled_port_count == 2'h3)
    else $error("fixed flag on an inactive reported port");
endmodule // hpcr_top

// ---- tb/hpcr_host_model.sv ----
// Board and host side of the hub: supply pin, re-map numbers and the host's view of fixed devices
`timescale 1ns/1ns
module hpcr_host_model import hpcr_pkg::*; (
  // Clock
  input wire logic pclk,
  // Board straps
  output logic self_powered_pin,
  output hpcr_portnum_t [3:1] remap_port_number,
  // Report seen during enumeration
  input wire hpcr_portvec_t desc_fixed_attach
);
  int unsigned own_desc_ports;
  initial begin
    self_powered_pin = 1'b0;
    remap_port_number = '0;
    own_desc_ports = 0;
  end
  // Straps change only just after an edge, like a real board switching supply
  task automatic set_straps(input logic pin, input hpcr_portnum_t [3:1] remap);
    self_powered_pin <= pin;
    remap_port_number <= remap;
  endtask
  // Fixed devices answer their own descriptor requests; the host never asks the hub for them
  always @(posedge pclk) begin
    own_desc_ports <= $countones(desc_fixed_attach);
  end
endmodule // hpcr_host_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the hub port configuration registers
`timescale 1ns/1ns
module tb_top import hpcr_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, self_powered_pin, compound_flag, port_numbering_select, string_enable;
  logic [31:0] prdata;
  hpcr_portnum_t [3:1] remap_port_number, port_number, e_num, remap;
  hpcr_portvec_t fixed_attach_bits, port_enabled, desc_fixed_attach, e_en, e_desc;
  hpcr_portnum_t enabled_port_count, e_cnt;
  hpcr_byte_t byte2 = 8'h28, byte3 = 8'h03, fx = 8'h06, sp = 8'h00, bp = 8'h00;
  logic pin = 1'b0;
  logic [8:0] exp_q[$];
  logic [8:0] e;
  int seed = 65815;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;

  always #5 pclk = ~pclk;

  hpcr_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .self_powered_pin(self_powered_pin), .remap_port_number(remap_port_number),
    .compound_flag(compound_flag), .port_numbering_select(port_numbering_select),
    .string_enable(string_enable), .fixed_attach_bits(fixed_attach_bits), .port_enabled(port_enabled),
    .port_number(port_number), .enabled_port_count(enabled_port_count), .desc_fixed_attach(desc_fixed_attach));

  hpcr_host_model host_u (.pclk(pclk), .self_powered_pin(self_powered_pin),
    .remap_port_number(remap_port_number), .desc_fixed_attach(desc_fixed_attach));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Expectation note {slverr, data} is queued before the request goes out
  task automatic apb(input logic w, input logic [7:0] a, d, input logic [3:0] s, input logic [8:0] x);
    exp_q.push_back(x);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      e = exp_q.pop_front();
      chk("pslverr", 32'(pslverr), 32'(e[8]));
      if (!pwrite) chk("prdata", prdata, {24'h0, e[7:0]});
    end
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      give_verdict();
    end
  end

  // Reference port report worked out from the mirrored register bytes and straps
  task automatic chk_out();
    hpcr_portvec_t m;
    hpcr_portnum_t n;
    m = pin ? sp[3:1] : bp[3:1];
    n = 2'h0;
    e_en = '0;
    e_num = '0;
    e_desc = '0;
    for (int p = 1; p <= 3; p++) begin
      if (byte3[3]) e_num[p] = remap[p];
      else if (!m[p]) begin
        n++;
        e_num[p] = n;
      end
      e_en[p] = (e_num[p] != 2'h0);
      if (e_en[p]) e_desc[e_num[p]] = e_desc[e_num[p]] | fx[p];
    end
    e_cnt = 2'($countones(e_en));
    chk("compound", 32'(compound_flag), 32'(byte2[3]));
    chk("numsel", 32'(port_numbering_select), 32'(byte3[3]));
    chk("string", 32'(string_enable), 32'(byte3[0]));
    chk("fixed", 32'(fixed_attach_bits), 32'(fx[3:1]));
    chk("enabled", 32'(port_enabled), 32'(e_en));
    chk("number", 32'(port_number), 32'(e_num));
    chk("count", 32'(enabled_port_count), 32'(e_cnt));
    chk("desc", 32'(desc_fixed_attach), 32'(e_desc));
    chk("own desc", host_u.own_desc_ports, 32'($countones(e_desc)));
  endtask

  task automatic rd_all();
    apb(0, 8'h1C, 8'h00, 4'hF, {1'b0, (byte2 & 8'h08) | 8'h20});
    apb(0, 8'h20, 8'h00, 4'hF, {1'b0, (byte3 & 8'h09) | 8'h02});
    apb(0, 8'h24, 8'h00, 4'hF, {1'b0, fx & 8'h0E});
    apb(0, 8'h28, 8'h00, 4'hF, {1'b0, sp & 8'h0E});
    apb(0, 8'h2C, 8'h00, 4'hF, {1'b0, bp & 8'h0E});
  endtask

  initial begin
    remap = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd_all();
    chk_out();
    // Refused accesses: strobe off, unmapped places
    apb(1, 8'h1C, 8'h00, 4'h0, 9'h000);
    apb(1, 8'h3C, 8'hFF, 4'hF, 9'h100);
    apb(0, 8'h3C, 8'h00, 4'hF, 9'h100);
    apb(0, 8'h00, 8'h00, 4'hF, 9'h100);
    rd_all();
    for (int i = 0; i < 40; i++) begin
      byte2 = 8'($random(seed));
      byte3 = 8'($random(seed));
      fx = 8'($random(seed));
      sp = 8'($random(seed));
      bp = 8'($random(seed));
      pin = 1'($random(seed));
      remap = 6'($random(seed));
      // First passes force the renumbering and report corners that random bytes rarely hit
      if (i < 3) begin
        pin = (i != 2);
        byte3 = 8'h00;
      end
      if (i == 0) sp = 8'h02;
      if (i == 1) begin
        sp = 8'h00;
        fx = 8'h0C;
      end
      if (i == 2) bp = 8'h02;
      if (byte2[3]) fx[1] = 1'b1;
      host_u.set_straps(pin, remap);
      apb(1, 8'h1C, byte2, 4'hF, 9'h000);
      apb(1, 8'h20, byte3, 4'hF, 9'h000);
      apb(1, 8'h24, fx, 4'hF, 9'h000);
      apb(1, 8'h28, sp, 4'hF, 9'h000);
      apb(1, 8'h2C, bp, 4'hF, 9'h000);
      repeat (4) @(posedge pclk);
      chk_out();
      rd_all();
    end
    // Mid-run reset: every byte and output must return to its reset state
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    {byte2, byte3, fx, sp, bp} = {8'h28, 8'h03, 8'h06, 8'h00, 8'h00};
    rd_all();
    chk_out();
    repeat (2) @(posedge pclk);
    give_verdict();
  end
endmodule // tb_top
